// ---- verilog/wes_top.sv ----
// Wake event status latches: two status registers recording wake sources,
// the wake enables, a power-on request and a maskable interrupt.
// Assumes a one-cycle register port and inputs synchronous to clk.
// Functional notes
// - A status bit reads one after its event, zero since last cleared.
// - Latched status bits reset to zero; status one bits 4 and 5 follow the group lines.
// - Status one bit 0 latches ring one falling edge, clears on read.
// - Status one bit 1 latches ring two falling edge, clears on read.
// - Bits 2 and 3 latch keyboard and mouse clock falls, read-clear.
// - Status one bit 6 latches infrared two falling edge, read-clear.
// - Status one bit 7 latches the alarm signal, clears on read.
// - Bits 4 and 5 show live group interrupts; reads never clear them.
// - Status two bits 0 and 1 latch serial receive falls, read-clear.
// - Status two bit 3 latches ring input assertion, clears on read.
// - Status two bit 5 latches consumer infrared wake, read-clear.
// - Status two bit 2 latches button press; never requests power.
// - Enabled latched ring and infrared events assert power-on low.
// - A source reaches power-on only when its enable bit is one.
`timescale 1ns/100ps

module wes_top
  import wes_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire wes_bus_req_t bus_req,
  input wire wes_src_t wake_src,
  output logic [7:0] rdata_reg,
  output logic power_on_request_n,
  output logic irq_reg
);

  // Latch outputs and their event pulses.
  logic [4:0] fall_one_sts;
  logic [4:0] fall_one_fired;
  logic [0:0] alarm_sts;
  logic [0:0] alarm_fired;
  logic [2:0] fall_two_sts;
  logic [2:0] fall_two_fired;
  logic [1:0] level_two_sts;
  logic [1:0] level_two_fired;

  // Register state.
  logic [7:0] enable_one_reg;
  logic [7:0] enable_two_reg;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_mask_reg;
  logic power_on_req_n_reg;

  // Assembled views and decode.
  logic [7:0] status_one;
  logic [7:0] status_two;
  logic [7:0] clear_one;
  logic [7:0] clear_two;
  logic [7:0] wake_hits;
  logic [7:0] irq_events;
  logic [7:0] rdata_next;
  logic power_on_next_n;
  logic rd_status_one;
  logic rd_status_two;

  assign rd_status_one = bus_req.rd && (bus_req.addr == WES_OFF_STATUS_ONE);
  assign rd_status_two = bus_req.rd && (bus_req.addr == WES_OFF_STATUS_TWO);

  // Falling edges on ring, keyboard, mouse and infrared pins.
  wes_event_latch #(
    .N(5),
    .FALL(1'b1)
  ) u_fall_one (
    .clk(clk),
    .rst_n(rst_n),
    .src({wake_src.infrared_input_two_pin, wake_src.mouse_clock_pin,
          wake_src.keyboard_clock_pin, wake_src.ring_two_pin,
          wake_src.ring_one_pin}),
    .clr({clear_one[WES_S1_IR_TWO], clear_one[WES_S1_MOUSE_CLK],
          clear_one[WES_S1_KBD_CLK], clear_one[WES_S1_RING_TWO],
          clear_one[WES_S1_RING_ONE]}),
    .fired(fall_one_fired),
    .status_reg(fall_one_sts)
  );

  // The alarm is a level from the clock block, caught while high.
  wes_event_latch #(
    .N(1),
    .FALL(1'b0)
  ) u_alarm (
    .clk(clk),
    .rst_n(rst_n),
    .src(wake_src.rtc_alarm),
    .clr(clear_one[WES_S1_RTC_ALARM]),
    .fired(alarm_fired),
    .status_reg(alarm_sts)
  );

  // Falling edges on both receive pins and on the active-low ring input.
  wes_event_latch #(
    .N(3),
    .FALL(1'b1)
  ) u_fall_two (
    .clk(clk),
    .rst_n(rst_n),
    .src({wake_src.ring_input_n, wake_src.serial_rx_two_pin,
          wake_src.serial_rx_one_pin}),
    .clr({clear_two[WES_S2_RING_PIN], clear_two[WES_S2_RX_TWO],
          clear_two[WES_S2_RX_ONE]}),
    .fired(fall_two_fired),
    .status_reg(fall_two_sts)
  );

  // Consumer infrared wake and button press arrive as high levels.
  wes_event_latch #(
    .N(2),
    .FALL(1'b0)
  ) u_level_two (
    .clk(clk),
    .rst_n(rst_n),
    .src({wake_src.cir_wake, wake_src.button_press}),
    .clr({clear_two[WES_S2_CIR], clear_two[WES_S2_BUTTON]}),
    .fired(level_two_fired),
    .status_reg(level_two_sts)
  );

  // First status view: latched bits plus the two live group interrupts.
  always_comb
  begin
    status_one = WES_RST_STATUS;
    status_one[WES_S1_RING_ONE] = fall_one_sts[0];
    status_one[WES_S1_RING_TWO] = fall_one_sts[1];
    status_one[WES_S1_KBD_CLK] = fall_one_sts[2];
    status_one[WES_S1_MOUSE_CLK] = fall_one_sts[3];
    status_one[WES_S1_GROUP_ONE] = wake_src.group_irq_one;
    status_one[WES_S1_GROUP_TWO] = wake_src.group_irq_two;
    status_one[WES_S1_IR_TWO] = fall_one_sts[4];
    status_one[WES_S1_RTC_ALARM] = alarm_sts[0];
  end

  // Second status view; unused positions stay zero.
  always_comb
  begin
    status_two = WES_RST_STATUS;
    status_two[WES_S2_RX_ONE] = fall_two_sts[0];
    status_two[WES_S2_RX_TWO] = fall_two_sts[1];
    status_two[WES_S2_RING_PIN] = fall_two_sts[2];
    status_two[WES_S2_BUTTON] = level_two_sts[0];
    status_two[WES_S2_CIR] = level_two_sts[1];
  end

  // Clear only what this read returns; live bits are never cleared.
  assign clear_one = rd_status_one ? (status_one & WES_S1_LATCH_MASK)
                                   : 8'h00;
  assign clear_two = rd_status_two ? (status_two & WES_S2_LATCH_MASK)
                                   : 8'h00;

  // Enabled sources; the button bit is left out of the wake mask.
  assign wake_hits = (status_one & enable_one_reg)
                   | (status_two & enable_two_reg & WES_S2_WAKE_MASK);
  assign power_on_next_n = ~|wake_hits;

  // Power-on request is registered so the pin never glitches.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      power_on_req_n_reg <= 1'b1;
    else
      power_on_req_n_reg <= power_on_next_n;
  end

  assign power_on_request_n = power_on_req_n_reg;

  // First enable register, all eight sources writable.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      enable_one_reg <= WES_RST_ENABLE_ONE;
    else if (bus_req.wr && bus_req.addr == WES_OFF_ENABLE_ONE)
      enable_one_reg <= bus_req.wdata;
  end

  // Second enable register; reserved bits are held at zero.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      enable_two_reg <= WES_RST_ENABLE_TWO;
    else if (bus_req.wr && bus_req.addr == WES_OFF_ENABLE_TWO)
      enable_two_reg <= bus_req.wdata & WES_ENABLE_TWO_MASK;
  end

  // Interrupt sources: new latched wakes, button, power request edge.
  always_comb
  begin
    irq_events = 8'h00;
    irq_events[WES_IRQ_LATCH_ONE] = |fall_one_fired | alarm_fired[0];
    irq_events[WES_IRQ_LATCH_TWO] = |fall_two_fired | level_two_fired[1];
    irq_events[WES_IRQ_BUTTON] = level_two_fired[0];
    irq_events[WES_IRQ_POWER_ON] = power_on_req_n_reg & ~power_on_next_n;
  end

  // Sticky interrupt status, write one to clear; a new event wins.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_status_reg <= WES_RST_IRQ;
    else if (bus_req.wr && bus_req.addr == WES_OFF_IRQ_STATUS)
      irq_status_reg <= irq_events | (irq_status_reg & ~bus_req.wdata);
    else
      irq_status_reg <= irq_events | irq_status_reg;
  end

  // Interrupt mask, one enables the matching status bit.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_mask_reg <= WES_RST_IRQ;
    else if (bus_req.wr && bus_req.addr == WES_OFF_IRQ_MASK)
      irq_mask_reg <= bus_req.wdata & WES_IRQ_IMPL_MASK;
  end

  // Level interrupt, one cycle behind status to keep the output a flop.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(irq_status_reg & irq_mask_reg);
  end

  // Read mux; unmapped offsets and idle cycles return zero.
  always_comb
  begin
    rdata_next = 8'h00;
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        WES_OFF_ENABLE_ONE: rdata_next = enable_one_reg;
        WES_OFF_ENABLE_TWO: rdata_next = enable_two_reg;
        WES_OFF_STATUS_ONE: rdata_next = status_one;
        WES_OFF_STATUS_TWO: rdata_next = status_two;
        WES_OFF_IRQ_STATUS: rdata_next = irq_status_reg;
        WES_OFF_IRQ_MASK: rdata_next = irq_mask_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  // Checks on the behaviour seen at the register port and power pin.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  ring_one_latch_a: assert property (
    $fell(wake_src.ring_one_pin) |=> status_one[WES_S1_RING_ONE])
    else $error("ring one fall not latched");

  ring_two_latch_a: assert property (
    $fell(wake_src.ring_two_pin) |=> status_one[WES_S1_RING_TWO])
    else $error("ring two fall not latched");

  kbd_mouse_latch_a: assert property (
    $fell(wake_src.keyboard_clock_pin) || $fell(wake_src.mouse_clock_pin)
    |=> status_one[WES_S1_KBD_CLK] || status_one[WES_S1_MOUSE_CLK])
    else $error("keyboard or mouse fall not latched");

  ir_two_latch_a: assert property (
    $fell(wake_src.infrared_input_two_pin) |=> status_one[WES_S1_IR_TWO])
    else $error("infrared fall not latched");

  alarm_hold_a: assert property (
    wake_src.rtc_alarm ##1 !rd_status_one [*2]
    |-> status_one[WES_S1_RTC_ALARM])
    else $error("alarm not held until read");

  group_live_a: assert property (
    rd_status_one |=> rdata_reg[5:4] ==
      $past({wake_src.group_irq_two, wake_src.group_irq_one}))
    else $error("group interrupt bits not live");

  rx_latch_a: assert property (
    $fell(wake_src.serial_rx_one_pin) |=> status_two[WES_S2_RX_ONE])
    else $error("receive fall not latched");

  ring_pin_latch_a: assert property (
    $fell(wake_src.ring_input_n) |=> status_two[WES_S2_RING_PIN])
    else $error("ring input not latched");

  cir_latch_a: assert property (
    wake_src.cir_wake |=> status_two[WES_S2_CIR])
    else $error("infrared wake not latched");

  button_no_power_a: assert property (
    status_two[WES_S2_BUTTON] && (status_one & enable_one_reg) == 8'h00
    && (status_two & enable_two_reg & ~(8'h01 << WES_S2_BUTTON)) == 8'h00
    |=> power_on_request_n)
    else $error("button press requested power");

  read_clears_a: assert property (
    rd_status_two && fall_two_fired == 3'h0 && level_two_fired == 2'h0
    |=> (status_two & WES_S2_LATCH_MASK) == 8'h00)
    else $error("status two not cleared by read");

  wake_asserts_a: assert property (
    |(status_one & enable_one_reg & WES_S1_LATCH_MASK)
    || |(status_two & enable_two_reg & WES_S2_WAKE_MASK)
    |=> !power_on_request_n)
    else $error("enabled wake did not request power");

  enable_gate_a: assert property (
    (status_one & enable_one_reg) == 8'h00
    && (status_two & enable_two_reg & WES_S2_WAKE_MASK) == 8'h00
    |=> power_on_request_n)
    else $error("disabled source requested power");

  reserved_zero_a: assert property (
    rd_status_two |=> (rdata_reg & ~WES_S2_LATCH_MASK) == 8'h00)
    else $error("reserved status bits not zero");

  idle_rdata_a: assert property (
    !bus_req.rd |=> rdata_reg == 8'h00)
    else $error("read data outside read cycle");

  // Main scenarios worth seeing in simulation.
  read_set_c: cover property (
    rd_status_one && status_one != 8'h00 ##1 rdata_reg != 8'h00);
  power_on_c: cover property ($fell(power_on_request_n));
  irq_c: cover property ($rose(irq_reg));
  button_c: cover property (
    rd_status_two && status_two[WES_S2_BUTTON]);

endmodule : wes_top

// ---- include/wes_pkg.sv ----
// Package for the wake event status latches: register offsets, bit
// positions, reset values and the structs that carry bus and pin groups.
// Assumes an 8-bit register port and synchronous wake source inputs.
package wes_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] WES_OFF_ENABLE_ONE = 8'hB0;
  localparam logic [7:0] WES_OFF_ENABLE_TWO = 8'hB1;
  localparam logic [7:0] WES_OFF_STATUS_ONE = 8'hB2;
  localparam logic [7:0] WES_OFF_STATUS_TWO = 8'hB3;
  localparam logic [7:0] WES_OFF_IRQ_STATUS = 8'hB4;
  localparam logic [7:0] WES_OFF_IRQ_MASK = 8'hB5;

  // Reset values.
  localparam logic [7:0] WES_RST_ENABLE_ONE = 8'h00;
  localparam logic [7:0] WES_RST_ENABLE_TWO = 8'h80;
  localparam logic [7:0] WES_RST_STATUS = 8'h00;
  localparam logic [7:0] WES_RST_IRQ = 8'h00;

  // Writable bits of the second enable register; the rest read as zero.
  localparam logic [7:0] WES_ENABLE_TWO_MASK = 8'hAB;

  // Bit positions in the first status register.
  localparam int WES_S1_RING_ONE = 0;
  localparam int WES_S1_RING_TWO = 1;
  localparam int WES_S1_KBD_CLK = 2;
  localparam int WES_S1_MOUSE_CLK = 3;
  localparam int WES_S1_GROUP_ONE = 4;
  localparam int WES_S1_GROUP_TWO = 5;
  localparam int WES_S1_IR_TWO = 6;
  localparam int WES_S1_RTC_ALARM = 7;

  // Bit positions in the second status register.
  localparam int WES_S2_RX_ONE = 0;
  localparam int WES_S2_RX_TWO = 1;
  localparam int WES_S2_BUTTON = 2;
  localparam int WES_S2_RING_PIN = 3;
  localparam int WES_S2_CIR = 5;

  // Bits of the first status register that latch and clear on read.
  localparam logic [7:0] WES_S1_LATCH_MASK = 8'hCF;
  // Implemented bits of the second status register.
  localparam logic [7:0] WES_S2_LATCH_MASK = 8'h2F;
  // Bits of the second status register that may request power on.
  localparam logic [7:0] WES_S2_WAKE_MASK = 8'h2B;

  // Bit positions in the interrupt status and mask registers.
  localparam int WES_IRQ_LATCH_ONE = 0;
  localparam int WES_IRQ_LATCH_TWO = 1;
  localparam int WES_IRQ_BUTTON = 2;
  localparam int WES_IRQ_POWER_ON = 3;
  localparam logic [7:0] WES_IRQ_IMPL_MASK = 8'h0F;

  // One register port request.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wes_bus_req_t;

  // Wake source pins and internal event signals.
  typedef struct packed {
    logic ring_one_pin;
    logic ring_two_pin;
    logic keyboard_clock_pin;
    logic mouse_clock_pin;
    logic infrared_input_two_pin;
    logic rtc_alarm;
    logic group_irq_one;
    logic group_irq_two;
    logic serial_rx_one_pin;
    logic serial_rx_two_pin;
    logic ring_input_n;
    logic cir_wake;
    logic button_press;
  } wes_src_t;

endpackage : wes_pkg

// ---- verilog/wes_event_latch.sv ----
// Vector of sticky event latches with priority of set over clear.
// Assumes sources are synchronous to clk and clr comes from a read.
`timescale 1ns/100ps

module wes_event_latch
  import wes_pkg::*;
#(
  parameter int N = 1,
  parameter bit FALL = 1'b1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [N-1:0] src,
  input wire logic [N-1:0] clr,
  output logic [N-1:0] fired,
  output logic [N-1:0] status_reg
);

  logic [N-1:0] prev_reg;

  // A zero-width latch vector cannot be built.
  if (N < 1)
  begin : g_bad_width
    $error("wes_event_latch needs N of at least one");
  end

  // Previous sample; idle level of the monitored pins is high.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prev_reg <= '1;
    else
      prev_reg <= src;
  end

  // Falling edge or plain high level, as chosen at elaboration.
  assign fired = FALL ? (prev_reg & ~src) : src;

  // A new event in the clear cycle survives, so no wake is lost.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      status_reg <= '0;
    else
      status_reg <= fired | (status_reg & ~clr);
  end

endmodule : wes_event_latch

// ---- verif/wes_src_model.sv ----
// Model of the wake sources: the monitored pins and internal event lines.
// Assumes the bench calls its tasks from a process timed by clk.
`timescale 1ns/100ps

module wes_src_model
  import wes_pkg::*;
(
  input wire logic clk,
  output wes_src_t wake_src
);
  // Pins idle high and event levels idle low; the ring input is active low.
  logic [12:0] lines_reg = 13'h1F1C;

  assign wake_src = wes_src_t'(lines_reg);

  // One cycle away from idle: a fall on a pin, a pulse on a level line.
  task automatic hit(input int i);
    @(posedge clk);
    lines_reg[i] <= ~lines_reg[i];
    @(posedge clk);
    lines_reg[i] <= ~lines_reg[i];
  endtask : hit

  // Group interrupts are levels that only their source clears.
  task automatic level(input int i, input logic b);
    @(posedge clk);
    lines_reg[i] <= b;
  endtask : level
endmodule : wes_src_model

// ---- verif/wes_top_test.sv ----
// Self-checking bench for the wake status latches and power request.
// Assumes the source model in wes_src_model and the package constants.
`timescale 1ns/100ps

module wes_top_test
  import wes_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  wes_bus_req_t bus_req = '0;
  wes_src_t wake_src;
  logic [7:0] rdata;
  logic pwr_n;
  logic irq;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;

  // A 5 ns clock.
  always #2.5 clk = ~clk;

  wes_top dut_u (
    .clk(clk),
    .rst_n(rst_n),
    .bus_req(bus_req),
    .wake_src(wake_src),
    .rdata_reg(rdata),
    .power_on_request_n(pwr_n),
    .irq_reg(irq)
  );

  wes_src_model src_u (
    .clk(clk),
    .wake_src(wake_src)
  );

  // Compare and count; a mismatch is reported at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Let edges pass, then step off the edge so its updates have landed.
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= {a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_req <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1;
    chk(rdata, exp);
  endtask : rdchk

  // Reset values, an unmapped place and writes to read-only status.
  task automatic t_reset();
    chk({6'h00, pwr_n, irq}, 8'h02);
    rdchk(WES_OFF_STATUS_ONE, 8'h00);
    rdchk(WES_OFF_STATUS_TWO, 8'h00);
    rdchk(WES_OFF_ENABLE_ONE, 8'h00);
    rdchk(WES_OFF_ENABLE_TWO, 8'h80);
    rdchk(8'h40, 8'h00);
    wr(WES_OFF_STATUS_ONE, 8'hFF);
    wr(WES_OFF_STATUS_TWO, 8'hFF);
    rdchk(WES_OFF_STATUS_ONE, 8'h00);
    rdchk(WES_OFF_STATUS_TWO, 8'h00);
  endtask : t_reset

  // Every latched source sets its own bit once and a read clears it.
  task automatic t_latch();
    int idx[11] = '{12, 11, 10, 9, 8, 7, 4, 3, 2, 1, 0};
    logic [7:0] bv[11] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h40, 8'h80,
      8'h01, 8'h02, 8'h08, 8'h20, 8'h04};
    logic [7:0] a;
    for (int k = 0; k < 11; k++)
    begin
      a = (k < 6) ? WES_OFF_STATUS_ONE : WES_OFF_STATUS_TWO;
      src_u.hit(idx[k]);
      settle(2);
      rdchk(a, bv[k]);
      rdchk(a, 8'h00);
    end
  endtask : t_latch

  // Group interrupt bits follow their level and survive reads.
  task automatic t_live();
    src_u.level(6, 1'b1);
    settle(2);
    rdchk(WES_OFF_STATUS_ONE, 8'h10);
    rdchk(WES_OFF_STATUS_ONE, 8'h10);
    src_u.level(6, 1'b0);
    src_u.level(5, 1'b1);
    settle(2);
    rdchk(WES_OFF_STATUS_ONE, 8'h20);
    src_u.level(5, 1'b0);
    settle(2);
    rdchk(WES_OFF_STATUS_ONE, 8'h00);
  endtask : t_live

  // The power request honours the enables and ignores the button.
  task automatic t_power();
    src_u.hit(12);
    settle(4);
    chk({7'h00, pwr_n}, 8'h01);
    rdchk(WES_OFF_STATUS_ONE, 8'h01);
    wr(WES_OFF_ENABLE_ONE, 8'h01);
    src_u.hit(12);
    settle(3);
    chk({7'h00, pwr_n}, 8'h00);
    rdchk(WES_OFF_STATUS_ONE, 8'h01);
    settle(1);
    chk({7'h00, pwr_n}, 8'h01);
    wr(WES_OFF_ENABLE_TWO, 8'hFF);
    src_u.hit(0);
    settle(4);
    chk({7'h00, pwr_n}, 8'h01);
    rdchk(WES_OFF_STATUS_TWO, 8'h04);
    src_u.hit(1);
    settle(3);
    chk({7'h00, pwr_n}, 8'h00);
    rdchk(WES_OFF_STATUS_TWO, 8'h20);
    settle(1);
    chk({7'h00, pwr_n}, 8'h01);
    wr(WES_OFF_ENABLE_ONE, 8'h10);
    src_u.level(6, 1'b1);
    settle(2);
    chk({7'h00, pwr_n}, 8'h00);
    src_u.level(6, 1'b0);
    settle(2);
    chk({7'h00, pwr_n}, 8'h01);
    wr(WES_OFF_ENABLE_ONE, 8'h00);
    wr(WES_OFF_ENABLE_TWO, 8'h80);
  endtask : t_power

  // An event landing in the very read that clears its register survives,
  // because the clear only touches the bits that read returned.
  task automatic t_race();
    src_u.hit(12);
    settle(2);
    fork
      src_u.hit(11);
      rdchk(WES_OFF_STATUS_ONE, 8'h01);
    join
    rdchk(WES_OFF_STATUS_ONE, 8'h02);
  endtask : t_race

  // The interrupt rises for an unmasked event and falls once cleared.
  task automatic t_irq();
    wr(WES_OFF_IRQ_STATUS, 8'h0F);
    rdchk(WES_OFF_IRQ_STATUS, 8'h00);
    wr(WES_OFF_IRQ_MASK, 8'h01);
    src_u.hit(12);
    settle(3);
    chk({7'h00, irq}, 8'h01);
    rdchk(WES_OFF_IRQ_STATUS, 8'h01);
    rdchk(WES_OFF_STATUS_ONE, 8'h01);
    wr(WES_OFF_IRQ_STATUS, 8'h01);
    settle(2);
    chk({7'h00, irq}, 8'h00);
    wr(WES_OFF_IRQ_MASK, 8'h00);
    src_u.hit(12);
    settle(3);
    chk({7'h00, irq}, 8'h00);
    rdchk(WES_OFF_IRQ_STATUS, 8'h01);
    rdchk(WES_OFF_STATUS_ONE, 8'h01);
  endtask : t_irq

  // A reset in mid-run drops the request and restores reset values.
  task automatic t_midreset();
    wr(WES_OFF_ENABLE_ONE, 8'h01);
    src_u.hit(12);
    settle(3);
    chk({7'h00, pwr_n}, 8'h00);
    @(posedge clk);
    rst_n <= 1'b0;
    settle(2);
    chk({6'h00, pwr_n, irq}, 8'h02);
    @(posedge clk);
    rst_n <= 1'b1;
    rdchk(WES_OFF_STATUS_ONE, 8'h00);
    rdchk(WES_OFF_ENABLE_ONE, 8'h00);
  endtask : t_midreset

  task automatic wrap_up();
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // A hang is cut short well past the few hundred cycles the run needs.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  // Reset for 16 cycles, then the scenarios in turn.
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_latch();
    t_live();
    t_power();
    t_race();
    t_irq();
    t_midreset();
    wrap_up();
  end
endmodule : wes_top_test
